/* File: cmp_analog_model.sv */
// Behavioural model of the analog comparator core that drives the raw decision.
module cmp_analog_model
(
    input  wire logic       powerOn,
    input  wire logic [1:0] respTimeSel,
    input  wire logic       level,
    output logic            decision
);
    timeunit 1ns;
    timeprecision 1ps;

    // unpowered low, slower when selected
    // A slower response setting delays the decision; an unpowered core reads low.
    // The decision starts low so the synchroniser never sees an unknown.
    initial
    begin
        decision = 1'b0;
        forever
        begin
            @(level or powerOn);
            decision <= #(respTimeSel) (powerOn & level);
        end
    end
endmodule

/* File: cmp_edge_irq.sv */
// Sticky edge flags, read-to-clear, and masked level interrupt.
module cmp_edge_irq
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic syncOut,
    input  wire logic clearRead,
    input  wire logic riseMask,
    input  wire logic fallMask,
    output logic      riseFlag,
    output logic      fallFlag,
    output logic      irq
);
    logic prev_reg;
    logic rise_reg;
    logic fall_reg;
    logic irq_reg;
    logic prev_next;
    logic rise_next;
    logic fall_next;
    logic irq_next;
    logic riseEvt;
    logic fallEvt;

    // A set in the clearing cycle wins, so no edge is lost.
    always_comb
    begin
        riseEvt   = syncOut & ~prev_reg;
        fallEvt   = ~syncOut & prev_reg;
        prev_next = syncOut;
        rise_next = riseEvt | (rise_reg & ~clearRead);
        fall_next = fallEvt | (fall_reg & ~clearRead);
        irq_next  = (rise_next & riseMask) | (fall_next & fallMask);
    end

    // Flag and interrupt registers.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev_reg <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
            irq_reg  <= 1'b0;
        end
        else
        begin
            prev_reg <= prev_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
            irq_reg  <= irq_next;
        end
    end

    assign riseFlag = rise_reg;
    assign fallFlag = fall_reg;
    assign irq      = irq_reg;
endmodule

/* File: cmp_edge_pkg.sv */
// Package with register map, field positions and reset values for the comparator control block.
package cmp_edge_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] CTRL_OFFS   = 8'h00;
    localparam logic [7:0] MODE_OFFS   = 8'h04;
    localparam logic [7:0] STATUS_OFFS = 8'h08;
    localparam logic [7:0] MASK_OFFS   = 8'h0C;
    // Control register fields.
    localparam int ENABLE_BIT   = 7;
    localparam int OUT_BIT      = 6;
    localparam int POS_HYST_LSB = 2;
    localparam int NEG_HYST_LSB = 0;
    localparam int HYST_W       = 2;
    // Mode register field.
    localparam int RESP_LSB = 0;
    localparam int RESP_W   = 2;
    // Status and mask register fields share one layout.
    localparam int RISE_BIT = 1;
    localparam int FALL_BIT = 0;
    // Reset values.
    localparam logic [HYST_W-1:0] HYST_RESET = 2'h0;
    localparam logic [RESP_W-1:0] RESP_RESET = 2'h2;
    // Hysteresis encodings: off, 5 mV, 10 mV, 20 mV nominal.
    localparam logic [HYST_W-1:0] HYST_OFF  = 2'h0;
    localparam logic [HYST_W-1:0] HYST_5MV  = 2'h1;
    localparam logic [HYST_W-1:0] HYST_10MV = 2'h2;
    localparam logic [HYST_W-1:0] HYST_20MV = 2'h3;
    // Synchroniser depth.
    localparam int SYNC_STAGES = 2;
endpackage

/* File: cmp_sync.sv */
// Two-stage synchroniser for the raw comparator decision.
module cmp_sync
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic [cmp_edge_pkg::SYNC_STAGES-1:0] stage_reg;
    logic [cmp_edge_pkg::SYNC_STAGES-1:0] stage_next;

    // The first stage feeds only the second, to keep metastability contained.
    always_comb
    begin
        stage_next = {stage_reg[cmp_edge_pkg::SYNC_STAGES-2:0], din};
    end

    // Stages start low, matching a disabled comparator.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            stage_reg <= '0;
        else
            stage_reg <= stage_next;
    end

    assign dout = stage_reg[cmp_edge_pkg::SYNC_STAGES-1];
endmodule

/* File: comparator_edge_control.sv */
// Top of the comparator control block: APB registers, outputs, edges and interrupt.
// Functional notes
// - Latched synchronous and raw asynchronous outputs provided.
// - Raw output works without the clock.
// - Disabled: outputs low, analog supply off.
// - Response-time field forwarded to analog core.
// - Negative hysteresis: off, 5, 10, 20 mV.
// - Positive hysteresis field set independently.
// - Falling output edge sets falling flag.
// - Rising output edge sets rising flag.
// - Flags stay set until software clears.
// - Rising mask lets rising flag interrupt.
// - Falling mask lets falling flag interrupt.
// - Output state readable any time.
// - Enable bit switches comparator on/off.
module comparator_edge_control
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmpDecision,
    output logic             rawCmpOut,
    output logic             latchedCmpOut,
    output logic             cmpPowerOn,
    output logic [1:0]       respTimeSel,
    output logic [1:0]       negHystSel,
    output logic [1:0]       posHystSel,
    output logic             cmpIrq
);
    logic        enable_reg;
    logic [1:0]  resp_reg;
    logic [1:0]  neg_reg;
    logic [1:0]  pos_reg;
    logic        riseMask_reg;
    logic        fallMask_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        latched_reg;
    logic        enable_next;
    logic [1:0]  resp_next;
    logic [1:0]  neg_next;
    logic [1:0]  pos_next;
    logic        riseMask_next;
    logic        fallMask_next;
    logic [31:0] prdata_next;
    logic        pready_next;
    logic        pslverr_next;
    logic        latched_next;
    logic        syncOut;
    logic        riseFlag;
    logic        fallFlag;
    logic        irqLevel;
    logic        statusRead;
    logic        access;
    logic        wrDone;

    // True when the address is one of the four mapped registers.
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == cmp_edge_pkg::CTRL_OFFS) || (a == cmp_edge_pkg::MODE_OFFS)
                || (a == cmp_edge_pkg::STATUS_OFFS) || (a == cmp_edge_pkg::MASK_OFFS);
    endfunction

    cmp_sync u_sync
    (
        .clk  (clk),
        .rst  (rst),
        .din  (cmpDecision),
        .dout (syncOut)
    );

    cmp_edge_irq u_edges
    (
        .clk       (clk),
        .rst       (rst),
        .syncOut   (syncOut),
        .clearRead (statusRead),
        // Next mask values, so the interrupt moves in the same cycle as the mask register.
        .riseMask  (riseMask_next),
        .fallMask  (fallMask_next),
        .riseFlag  (riseFlag),
        .fallFlag  (fallFlag),
        .irq       (irqLevel)
    );

    // Access phase of an APB transfer; the slave answers after one wait state.
    assign access     = psel & penable & ~pready_reg;
    // Writes land at the completing edge, where the master samples pready high.
    assign wrDone     = psel & penable & pwrite & pready_reg;
    assign statusRead = access & ~pwrite & (paddr == cmp_edge_pkg::STATUS_OFFS);

    // Register writes, read mux and bus answer.
    always_comb
    begin
        enable_next   = enable_reg;
        resp_next     = resp_reg;
        neg_next      = neg_reg;
        pos_next      = pos_reg;
        riseMask_next = riseMask_reg;
        fallMask_next = fallMask_reg;
        prdata_next   = 32'h0000_0000;
        pready_next   = access;
        pslverr_next  = access & ~isMapped(paddr);
        if (wrDone)
        begin
            case (paddr)
                cmp_edge_pkg::CTRL_OFFS:
                begin
                    enable_next = pwdata[cmp_edge_pkg::ENABLE_BIT];
                    neg_next = pwdata[cmp_edge_pkg::NEG_HYST_LSB +: cmp_edge_pkg::HYST_W];
                    pos_next = pwdata[cmp_edge_pkg::POS_HYST_LSB +: cmp_edge_pkg::HYST_W];
                end
                cmp_edge_pkg::MODE_OFFS:
                begin
                    resp_next = pwdata[cmp_edge_pkg::RESP_LSB +: cmp_edge_pkg::RESP_W];
                end
                cmp_edge_pkg::MASK_OFFS:
                begin
                    riseMask_next = pwdata[cmp_edge_pkg::RISE_BIT];
                    fallMask_next = pwdata[cmp_edge_pkg::FALL_BIT];
                end
                default:
                begin
                    enable_next = enable_reg;
                end
            endcase
        end
        else if (access && !pwrite)
        begin
            case (paddr)
                cmp_edge_pkg::CTRL_OFFS:
                begin
                    prdata_next[cmp_edge_pkg::ENABLE_BIT] = enable_reg;
                    prdata_next[cmp_edge_pkg::OUT_BIT] = syncOut;
                    prdata_next[cmp_edge_pkg::NEG_HYST_LSB +: cmp_edge_pkg::HYST_W] = neg_reg;
                    prdata_next[cmp_edge_pkg::POS_HYST_LSB +: cmp_edge_pkg::HYST_W] = pos_reg;
                end
                cmp_edge_pkg::MODE_OFFS:
                    prdata_next[cmp_edge_pkg::RESP_LSB +: cmp_edge_pkg::RESP_W] = resp_reg;
                cmp_edge_pkg::STATUS_OFFS:
                begin
                    prdata_next[cmp_edge_pkg::RISE_BIT] = riseFlag;
                    prdata_next[cmp_edge_pkg::FALL_BIT] = fallFlag;
                end
                cmp_edge_pkg::MASK_OFFS:
                begin
                    prdata_next[cmp_edge_pkg::RISE_BIT] = riseMask_reg;
                    prdata_next[cmp_edge_pkg::FALL_BIT] = fallMask_reg;
                end
                default:
                    prdata_next = 32'h0000_0000;
            endcase
        end
        // latched pin output gated by enable
        latched_next = enable_reg & syncOut;
    end

    // Register bank and bus outputs.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            enable_reg   <= 1'b0;
            resp_reg     <= cmp_edge_pkg::RESP_RESET;
            neg_reg      <= cmp_edge_pkg::HYST_RESET;
            pos_reg      <= cmp_edge_pkg::HYST_RESET;
            riseMask_reg <= 1'b0;
            fallMask_reg <= 1'b0;
            prdata_reg   <= 32'h0000_0000;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
            latched_reg  <= 1'b0;
        end
        else
        begin
            enable_reg   <= enable_next;
            resp_reg     <= resp_next;
            neg_reg      <= neg_next;
            pos_reg      <= pos_next;
            riseMask_reg <= riseMask_next;
            fallMask_reg <= fallMask_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
            latched_reg  <= latched_next;
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
    assign latchedCmpOut = latched_reg;
    assign cmpPowerOn    = enable_reg;
    assign respTimeSel   = resp_reg;
    assign negHystSel    = neg_reg;
    assign posHystSel    = pos_reg;
    assign cmpIrq        = irqLevel;
    // raw path has no flop, so it survives a stopped clock.
    // This one output is combinational by necessity: it must work without clk.
    assign rawCmpOut = cmpDecision & enable_reg;

    chk_irq_masked: assert property (@(posedge clk) disable iff (rst)
        ((riseFlag & riseMask_reg) | (fallFlag & fallMask_reg)) |-> cmpIrq)
        else $error("Interrupt missing while a masked-in flag is set.");

    chk_rise_sets: assert property (@(posedge clk) disable iff (rst)
        $rose(syncOut) |=> riseFlag)
        else $error("Rising edge did not set the rising flag.");

    chk_fall_sets: assert property (@(posedge clk) disable iff (rst)
        $fell(syncOut) |=> fallFlag)
        else $error("Falling edge did not set the falling flag.");

    // rising flag holds without a status read
    chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
        (riseFlag && !statusRead) |=> riseFlag)
        else $error("Rising flag dropped without a clear.");

    chk_off_low: assert property (@(posedge clk) disable iff (rst)
        !enable_reg |=> !latchedCmpOut)
        else $error("Latched output high while disabled.");

    chk_sync_path: assert property (@(posedge clk) disable iff (rst)
        enable_reg |=> (latchedCmpOut == $past(syncOut)))
        else $error("Latched output does not follow the synchronised decision.");

    chk_enable_wr: assert property (@(posedge clk) disable iff (rst)
        (wrDone && paddr == cmp_edge_pkg::CTRL_OFFS)
        |=> (cmpPowerOn == $past(pwdata[cmp_edge_pkg::ENABLE_BIT])))
        else $error("Enable write not applied.");

    chk_resp_wr: assert property (@(posedge clk) disable iff (rst)
        (wrDone && paddr == cmp_edge_pkg::MODE_OFFS)
        |=> (respTimeSel == $past(pwdata[cmp_edge_pkg::RESP_LSB +: cmp_edge_pkg::RESP_W])))
        else $error("Response time write not forwarded.");

    chk_neg_hyst: assert property (@(posedge clk) disable iff (rst)
        (wrDone && paddr == cmp_edge_pkg::CTRL_OFFS)
        |=> (negHystSel == $past(pwdata[cmp_edge_pkg::NEG_HYST_LSB +: cmp_edge_pkg::HYST_W])))
        else $error("Negative hysteresis write not forwarded.");

    chk_pos_hyst: assert property (@(posedge clk) disable iff (rst)
        (wrDone && paddr == cmp_edge_pkg::CTRL_OFFS)
        |=> (posHystSel == $past(pwdata[cmp_edge_pkg::POS_HYST_LSB +: cmp_edge_pkg::HYST_W])))
        else $error("Positive hysteresis write not forwarded.");

    // no interrupt without a masked-in flag
    chk_irq_quiet: assert property (@(posedge clk) disable iff (rst)
        !((riseFlag & riseMask_reg) | (fallFlag & fallMask_reg)) |-> !cmpIrq)
        else $error("Interrupt raised with no masked-in flag set.");

    // falling flag holds without a status read
    chk_fall_sticky: assert property (@(posedge clk) disable iff (rst)
        (fallFlag && !statusRead) |=> fallFlag)
        else $error("Falling flag dropped without a clear.");

    // a status read clears the rising flag unless a new edge arrives
    chk_rise_clear: assert property (@(posedge clk) disable iff (rst)
        (statusRead && !$rose(syncOut)) |=> !riseFlag)
        else $error("Rising flag not cleared by a status read.");

    // a status read clears the falling flag unless a new edge arrives
    chk_fall_clear: assert property (@(posedge clk) disable iff (rst)
        (statusRead && !$fell(syncOut)) |=> !fallFlag)
        else $error("Falling flag not cleared by a status read.");

    // output state bit carries the synchronised decision
    chk_out_state: assert property (@(posedge clk) disable iff (rst)
        (access && !pwrite && paddr == cmp_edge_pkg::CTRL_OFFS)
        |=> (prdata[cmp_edge_pkg::OUT_BIT] == $past(syncOut)))
        else $error("Output state bit does not show the decision.");

    // raw pin output low while disabled
    chk_raw_off: assert property (@(posedge clk) disable iff (rst)
        !enable_reg |-> !rawCmpOut)
        else $error("Raw output high while disabled.");

    // Bus answer: one wait state, then a ready pulse of exactly one cycle.
    sequence accessSeen;
        access;
    endsequence

    sequence answerPulse;
        pready ##1 !pready;
    endsequence

    chk_bus_answer: assert property (@(posedge clk) disable iff (rst)
        accessSeen |=> answerPulse)
        else $error("Bus answer is not a single ready pulse.");
endmodule

/* File: comparator_edge_control_tb_top.sv */
// Self-checking testbench for the comparator control block.
module comparator_edge_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cmpDecision;
    logic        rawCmpOut;
    logic        latchedCmpOut;
    logic        cmpPowerOn;
    logic [1:0]  respTimeSel;
    logic [1:0]  negHystSel;
    logic [1:0]  posHystSel;
    logic        cmpIrq;
    logic        level;
    logic [31:0] rd;
    logic        err;
    int          errorCnt;
    int          nTests;

    comparator_edge_control u_comparator_edge_control
    (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmpDecision(cmpDecision), .rawCmpOut(rawCmpOut),
        .latchedCmpOut(latchedCmpOut), .cmpPowerOn(cmpPowerOn),
        .respTimeSel(respTimeSel), .negHystSel(negHystSel),
        .posHystSel(posHystSel), .cmpIrq(cmpIrq)
    );

    cmp_analog_model u_cmp_analog_model
    (
        .powerOn(cmpPowerOn), .respTimeSel(respTimeSel), .level(level),
        .decision(cmpDecision)
    );

    // Half period of 2.5 ns gives the 200 MHz clock.
    always #2.5 clk = ~clk;

    // One comparison; unknowns never match.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            errorCnt++;
        end
    endtask

    // One APB transfer; pready is sampled at each rising edge, never assumed.
    task automatic apbXfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
        // One idle edge, so no strobe is assigned twice in one time step
        // and a write that landed at the completing edge is visible on return.
        @(posedge clk);
    endtask

    task automatic rdChk(input logic [7:0] addr, input logic [31:0] exp);
        apbXfer(1'b0, addr, 32'h0);
        chk("prdata", exp, rd);
    endtask

    task automatic giveVerdict();
        $display("Comparisons %0d, mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        #20000;
        errorCnt++;
        giveVerdict();
    end

    // Main sequence; every input changes just after a rising edge.
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        level = 1'b0;
        errorCnt = 0;
        nTests = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdChk(cmp_edge_pkg::CTRL_OFFS, 32'h0);
        rdChk(cmp_edge_pkg::MODE_OFFS, 32'h2);
        rdChk(cmp_edge_pkg::STATUS_OFFS, 32'h0);
        rdChk(cmp_edge_pkg::MASK_OFFS, 32'h0);
        // Every response and hysteresis code, the two fields set apart.
        for (int i = 0; i < 4; i++)
        begin
            apbXfer(1'b1, cmp_edge_pkg::MODE_OFFS, 32'(i));
            chk("respTimeSel", 32'(i), {30'h0, respTimeSel});
            apbXfer(1'b1, cmp_edge_pkg::CTRL_OFFS, 32'(i | ((3 - i) << 2)));
            chk("negHystSel", 32'(i), {30'h0, negHystSel});
            chk("posHystSel", 32'(3 - i), {30'h0, posHystSel});
        end
        apbXfer(1'b0, 8'h10, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("prdata", 32'h0, rd);
        // High input while disabled must not reach the pins.
        level <= 1'b1;
        apbXfer(1'b1, cmp_edge_pkg::CTRL_OFFS, 32'h0);
        repeat (5) @(posedge clk);
        chk("rawCmpOut", 32'h0, {31'h0, rawCmpOut});
        chk("latchedCmpOut", 32'h0, {31'h0, latchedCmpOut});
        chk("cmpPowerOn", 32'h0, {31'h0, cmpPowerOn});
        rdChk(cmp_edge_pkg::STATUS_OFFS, 32'h0);
        apbXfer(1'b1, cmp_edge_pkg::CTRL_OFFS, 32'h80);
        chk("cmpPowerOn", 32'h1, {31'h0, cmpPowerOn});
        chk("rawCmpOut", 32'h1, {31'h0, rawCmpOut});
        repeat (4) @(posedge clk);
        chk("latchedCmpOut", 32'h1, {31'h0, latchedCmpOut});
        rdChk(cmp_edge_pkg::CTRL_OFFS, 32'hC0);
        repeat (10) @(posedge clk);
        rdChk(cmp_edge_pkg::STATUS_OFFS, 32'h2);
        rdChk(cmp_edge_pkg::STATUS_OFFS, 32'h0);
        // The raw output follows between edges while the latched one lags.
        level <= 1'b0;
        #4;
        chk("rawCmpOut", 32'h0, {31'h0, rawCmpOut});
        chk("latchedCmpOut", 32'h1, {31'h0, latchedCmpOut});
        repeat (6) @(posedge clk);
        rdChk(cmp_edge_pkg::STATUS_OFFS, 32'h1);
        // Flags are cleared before any mask is opened.
        rdChk(cmp_edge_pkg::STATUS_OFFS, 32'h0);
        apbXfer(1'b1, cmp_edge_pkg::MASK_OFFS, 32'h2);
        level <= 1'b1;
        repeat (6) @(posedge clk);
        chk("cmpIrq", 32'h1, {31'h0, cmpIrq});
        rdChk(cmp_edge_pkg::STATUS_OFFS, 32'h2);
        repeat (2) @(posedge clk);
        chk("cmpIrq", 32'h0, {31'h0, cmpIrq});
        level <= 1'b0;
        repeat (6) @(posedge clk);
        chk("cmpIrq", 32'h0, {31'h0, cmpIrq});
        apbXfer(1'b1, cmp_edge_pkg::MASK_OFFS, 32'h1);
        repeat (2) @(posedge clk);
        chk("cmpIrq", 32'h1, {31'h0, cmpIrq});
        rdChk(cmp_edge_pkg::STATUS_OFFS, 32'h1);
        repeat (2) @(posedge clk);
        chk("cmpIrq", 32'h0, {31'h0, cmpIrq});
        giveVerdict();
    end
endmodule
